/* core/rcdri_pkg.sv */
// Contract
// R1: controller holds reset low 200 us; rcdri_ctrl_model holds it only HOLD_CYCLES (6) sys_clk cycles after resetReq
// R2: inputs ignored while reset low
// R3: control registers return to defaults
// R4: clock enables low, others float
// R5: low power, termination off in reset
// R6: controller keeps chip selects high before release; rcdri_ctrl_model drives them low early in midReset's reset
// R7: controller holds clock enables low; rcdri_ctrl_model drives them high early in midReset's reset
// R8: no forwarding until stabilization period ends
// R9: controller drives reset to valid level
// R10: leave reset only on release with clock
// R11: reset assertion fully asynchronous
// R12: clear stages, outputs float, enables low
// R13: release synchronized, assertion asynchronous
package rcdri_pkg;
  localparam int CLK_MHZ = 100;
  localparam int STAB_US = 15;
  localparam int STAB_CYCLES = STAB_US * CLK_MHZ;
  localparam int CS_W = 4;
  localparam int CA_W = 22;
  localparam int CTL_W = 8;
  localparam logic [CTL_W-1:0] CTL_DEFAULT = 8'h00;
  localparam int CNT_W = 16;

  typedef struct packed {
    logic [CS_W-1:0] chipSelectInputs;
    logic            clockEnableInput0;
    logic            clockEnableInput1;
    logic [CA_W-1:0] cmdAddr;
  } rcdri_in_s;

  typedef struct packed {
    logic [CS_W-1:0] chipSelect;
    logic [CA_W-1:0] cmdAddr;
  } rcdri_out_s;
endpackage

/* core/rcdri_top.sv */
`timescale 1ns/1ps
module rcdri_top #(
  parameter int STAB_CYCLES_P = rcdri_pkg::STAB_CYCLES
) (
  input  wire logic                     sys_clk,
  input  wire logic                     rst_n,
  input  wire rcdri_pkg::rcdri_in_s     regIn,
  input  wire logic                     ctlWrite,
  input  wire logic [rcdri_pkg::CTL_W-1:0] ctlData,
  output rcdri_pkg::rcdri_out_s         regOut,
  output logic                          regOutEn,
  output logic                          sideAClockEnableOut0,
  output logic                          sideAClockEnableOut1,
  output logic                          sideBClockEnableOut0,
  output logic                          sideBClockEnableOut1,
  output logic                          clockOutEn,
  output logic                          terminationEn,
  output logic                          receiverEn,
  output logic [rcdri_pkg::CTL_W-1:0]   ctlReg,
  output logic                          ready
);
  import rcdri_pkg::*;

  typedef enum logic [1:0] {RESET_ST, STAB_ST, RUN_ST} rcdri_state_e;

  function automatic logic [CNT_W-1:0] cntInc(input logic [CNT_W-1:0] value);
    return value + CNT_W'(1);
  endfunction

  // R13 release synchronizer
  logic syncA_q, syncB_q;
  logic syncA_d, syncB_d;

  always_comb begin
    syncA_d = 1'b1;
    syncB_d = syncA_q;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= syncA_d;
      syncB_q <= syncB_d;
    end
  end

  rcdri_state_e    state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CTL_W-1:0] ctl_d;
  rcdri_out_s      out_d;
  logic            outEn_d, cke_d, cke1_d, term_d, run_d;

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    ctl_d   = ctlReg;
    out_d   = regOut;
    outEn_d = 1'b0;
    cke_d   = 1'b0;
    term_d  = 1'b0;
    run_d   = 1'b0;
    cke1_d  = 1'b0;
    case (state_q)
      RESET_ST: begin
        // R10 leave only after synchronized release
        if (syncB_q) begin
          state_d = STAB_ST;
          cnt_d   = '0;
        end
      end
      STAB_ST: begin
        outEn_d = 1'b1;
        term_d  = 1'b1;
        // R8 hold data until stabilization ends
        if (cnt_q == CNT_W'(STAB_CYCLES_P - 1)) begin
          state_d = RUN_ST;
        end else begin
          cnt_d = cntInc(cnt_q);
        end
      end
      RUN_ST: begin
        outEn_d = 1'b1;
        term_d  = 1'b1;
        run_d   = 1'b1;
        out_d.chipSelect = regIn.chipSelectInputs;
        out_d.cmdAddr    = regIn.cmdAddr;
        cke_d   = regIn.clockEnableInput0;
        cke1_d  = regIn.clockEnableInput1;
        if (ctlWrite && (&regIn.chipSelectInputs == 1'b0)) begin
          ctl_d = ctlData;
        end
      end
      default: state_d = RESET_ST;
    endcase
  end

  // R11 asynchronous entry into reset
  // R2 R3 R4 R5 R12 reset outputs and state
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q              <= RESET_ST;
      cnt_q                <= '0;
      ctlReg               <= CTL_DEFAULT;
      regOut               <= '1;
      regOutEn             <= 1'b0;
      sideAClockEnableOut0 <= 1'b0;
      sideAClockEnableOut1 <= 1'b0;
      sideBClockEnableOut0 <= 1'b0;
      sideBClockEnableOut1 <= 1'b0;
      clockOutEn           <= 1'b0;
      terminationEn        <= 1'b0;
      receiverEn           <= 1'b0;
      ready                <= 1'b0;
    end else begin
      state_q              <= state_d;
      cnt_q                <= cnt_d;
      ctlReg               <= ctl_d;
      regOut               <= out_d;
      regOutEn             <= outEn_d;
      sideAClockEnableOut0 <= cke_d;
      sideAClockEnableOut1 <= cke1_d;
      sideBClockEnableOut0 <= cke_d;
      sideBClockEnableOut1 <= cke1_d;
      clockOutEn           <= outEn_d;
      terminationEn        <= term_d;
      receiverEn           <= term_d;
      ready                <= run_d;
    end
  end

  // helper: cycles since release seen
  logic [CNT_W-1:0] relCnt_q, relCnt_d;

  always_comb begin
    relCnt_d = relCnt_q;
    if (syncB_q && relCnt_q != '1) begin
      relCnt_d = cntInc(relCnt_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      relCnt_q <= '0;
    end else begin
      relCnt_q <= relCnt_d;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  stab_wait_a: assert property (ready |-> relCnt_q > CNT_W'(STAB_CYCLES_P)) // R8
    else $error("forwarding before stabilization");
  cke_hold_a: assert property (!ready |-> !sideAClockEnableOut0 && !sideAClockEnableOut1 && !sideBClockEnableOut0 && !sideBClockEnableOut1) // R8
    else $error("clock enable high before run");
  float_out_a: assert property (state_q == RESET_ST |-> !regOutEn && !clockOutEn) // R12
    else $error("outputs driven in reset");
  low_power_a: assert property (state_q == RESET_ST |-> !terminationEn && !receiverEn) // R5
    else $error("termination on in reset");
  sync_rel_a: assert property ($rose(syncB_q) |=> state_q == STAB_ST) // R13
    else $error("release not taken");
  leave_gate_a: assert property (state_q == RESET_ST && !syncB_q |=> state_q == RESET_ST) // R10
    else $error("left reset early");
  ctl_keep_a: assert property (state_q != RUN_ST |=> $stable(ctlReg)) // R2
    else $error("control changed outside run");
  ctl_default_a: assert property ($rose(syncB_q) |-> ctlReg == CTL_DEFAULT) // R3
    else $error("control not default");
  stab_len_a: assert property ($rose(state_q == STAB_ST) |-> ##1 state_q == STAB_ST) // R8
    else $error("stabilization cut short");

  property outHoldP;
    state_q != RUN_ST |=> $stable(regOut);
  endproperty
  out_hold_a: assert property (outHoldP) // R2
    else $error("data outputs moved outside run");

  property fwdDataP;
    state_q == RUN_ST |=> regOut == $past({regIn.chipSelectInputs, regIn.cmdAddr});
  endproperty
  fwd_data_a: assert property (fwdDataP) // R8
    else $error("run data not forwarded");

  property ckeFwdP;
    state_q == RUN_ST |=> sideAClockEnableOut0 == $past(regIn.clockEnableInput0) &&
      sideAClockEnableOut1 == $past(regIn.clockEnableInput1);
  endproperty
  cke_fwd_a: assert property (ckeFwdP) // R8
    else $error("clock enable not forwarded");

  property ckeCopyP;
    sideBClockEnableOut0 == sideAClockEnableOut0 && sideBClockEnableOut1 == sideAClockEnableOut1;
  endproperty
  cke_copy_a: assert property (ckeCopyP) // R4
    else $error("clock enable sides differ");

  property readyRunP;
    ready |-> state_q == RUN_ST;
  endproperty
  ready_run_a: assert property (readyRunP) // R8
    else $error("ready outside run");

  property stabBoundP;
    state_q == STAB_ST |-> cnt_q < CNT_W'(STAB_CYCLES_P);
  endproperty
  stab_bound_a: assert property (stabBoundP) // R8
    else $error("stabilization count overrun");

  property ctlResetP;
    state_q == RESET_ST |-> ctlReg == CTL_DEFAULT;
  endproperty
  ctl_reset_a: assert property (ctlResetP) // R3
    else $error("control not default in reset");

  property syncOrderP;
    syncB_q |-> syncA_q;
  endproperty
  sync_order_a: assert property (syncOrderP) // R13
    else $error("synchronizer stages out of order");

  release_cov: cover property ($rose(syncB_q));
  run_cov: cover property ($rose(ready));
  write_cov: cover property (ready && ctlWrite);
  stab_cov: cover property ($rose(state_q == STAB_ST));
  cke1_cov: cover property (sideAClockEnableOut1);
endmodule // rcdri_top

/* dv/rcdri_ctrl_model.sv */
`timescale 1ns/1ps
module rcdri_ctrl_model #(
  parameter int HOLD_CYCLES = 6
) (
  input  wire logic                 sys_clk,
  input  wire logic                 resetReq,
  input  wire logic                 userPhase,
  input  wire rcdri_pkg::rcdri_in_s userIn,
  output logic                      rstN,
  output rcdri_pkg::rcdri_in_s      regIn
);
  int holdCnt = HOLD_CYCLES;
  logic [rcdri_pkg::CA_W-1:0] idleAddr = '0;
  assign rstN = !resetReq && holdCnt == 0;
  always @(negedge sys_clk or posedge resetReq) begin
    if (resetReq) holdCnt <= HOLD_CYCLES;
    else if (holdCnt > 0) holdCnt <= holdCnt - 1;
  end
  always @(negedge sys_clk) idleAddr <= ~idleAddr;
  assign regIn = userPhase ? userIn : {{rcdri_pkg::CS_W{1'b1}}, 1'b0, 1'b0, idleAddr};
endmodule // rcdri_ctrl_model

/* dv/rcdri_top_tb_top.sv */
`timescale 1ns/1ps
module rcdri_top_tb_top;
  import rcdri_pkg::*;
  localparam int STAB_SIM = 20;
  logic       sysClk = 1'b0;
  logic       rstN;
  logic       resetReq = 1'b0;
  logic       userPhase = 1'b0;
  logic       ctlWrite = 1'b0;
  logic [7:0] ctlData = 8'h00;
  rcdri_in_s  userIn = '0;
  rcdri_in_s  regIn;
  rcdri_out_s regOut;
  wire  [3:0] ckeOut;
  logic       regOutEn, clockOutEn, terminationEn, receiverEn, ready;
  logic [7:0] ctlReg;
  int         err_total = 0;
  int         check_count = 0;
  initial forever #5 sysClk = ~sysClk;
  rcdri_ctrl_model rcdri_ctrl_model_inst (.sys_clk(sysClk), .resetReq(resetReq), .userPhase(userPhase),
    .userIn(userIn), .rstN(rstN), .regIn(regIn));
  rcdri_top #(.STAB_CYCLES_P(STAB_SIM)) rcdri_top_inst (.sys_clk(sysClk), .rst_n(rstN), .regIn(regIn),
    .ctlWrite(ctlWrite), .ctlData(ctlData), .regOut(regOut), .regOutEn(regOutEn),
    .sideAClockEnableOut0(ckeOut[0]), .sideAClockEnableOut1(ckeOut[1]), .sideBClockEnableOut0(ckeOut[2]),
    .sideBClockEnableOut1(ckeOut[3]), .clockOutEn(clockOutEn), .terminationEn(terminationEn),
    .receiverEn(receiverEn), .ctlReg(ctlReg), .ready(ready));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic inReset();
    chk(32'({regOutEn, ckeOut, clockOutEn, terminationEn, receiverEn, ready, ctlReg}), 32'h0);
    chk(32'(regOut), 32'h3FFFFFF);
  endtask
  task automatic waitReady();
    int n;
    int relN;
    n = 0;
    relN = 0;
    while (!ready && n < 200) begin
      chk(32'({ckeOut, regOut}), 32'h3FFFFFF);
      if (rstN) relN++;
      @(negedge sysClk);
      n++;
    end
    chk(32'(relN >= STAB_SIM), 32'h1);
    chk(32'(relN), 32'(STAB_SIM + 3));
    if (n >= 200) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic runCheck(input logic [3:0] cs, input logic cke0, input logic cke1, input logic [21:0] addr,
                          input logic [7:0] data);
    chk(32'(ctlReg), 32'h0);
    chk(32'({regOutEn, clockOutEn, terminationEn, receiverEn, ready}), 32'h1F);
    userPhase = 1'b1;
    userIn = '{cs, cke0, cke1, addr};
    ctlWrite = 1'b1;
    ctlData = data;
    repeat (2) @(negedge sysClk);
    ctlWrite = 1'b0;
    chk(32'(regOut), 32'({cs, addr}));
    chk(32'({ckeOut, ctlReg}), 32'({cke1, cke0, cke1, cke0, ((&cs) ? 8'h00 : data)}));
  endtask
  task automatic midReset();
    #3 resetReq = 1'b1;
    #1 inReset();
    @(negedge sysClk);
    resetReq = 1'b0;
    userIn = '{4'h0, 1'b1, 1'b1, 22'h155555};
    ctlWrite = 1'b1;
    ctlData = 8'h3C;
    repeat (3) @(negedge sysClk);
    inReset();
    userPhase = 1'b0;
    ctlWrite = 1'b0;
    waitReady();
  endtask
  initial begin
    @(negedge sysClk);
    inReset();
    waitReady();
    runCheck(4'hE, 1'b1, 1'b0, 22'h2AAAAA, 8'hA5);
    midReset();
    runCheck(4'hF, 1'b0, 1'b1, 22'h155555, 8'h3C);
    summarize();
  end
endmodule // rcdri_top_tb_top
